// ==== logic/switch_global_frame_policy.sv ====
// AHB-Lite register slice for the global frame policy, plus the frame judge.
// Assumes one AHB-Lite master, word transfers and straps stable around reset.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "gfp_defines.svh"
module switch_global_frame_policy #(
	parameter int LEN_W = 11 // Frame length width
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Strap pins, asynchronous
	input wire logic backoff_strap_pin,
	input wire logic collision_drop_strap_pin,
	input wire logic frame_size_strap_pin,
	// Backoff level to the MACs
	output logic aggressive_backoff,
	// Frame length check
	input wire logic frame_valid,
	input wire logic [LEN_W-1:0] frame_len,
	input wire logic frame_tagged,
	input wire logic frame_special_tag_id,
	output logic frame_drop,
	output logic frame_accept,
	// Collisions
	input wire logic coll_event,
	input wire logic [4:0] coll_count,
	output logic coll_discard,
	// Storm classification
	input wire logic dest_valid,
	input wire logic dest_bcast,
	input wire logic dest_mcast,
	output logic storm_hit,
	// Egress contention
	input wire logic fc_contend,
	output logic nonfc_drop_en,
	output logic fc_pause
);

	// Transfer type bit marking NONSEQ or SEQ
	localparam int TRANS_ACTIVE = 1;
	// Only whole words are written
	localparam logic [2:0] SIZE_WORD = 3'h2;

	// Limits need 11 bits; a narrower length field would wrap the jumbo limit
	if (LEN_W < 11) begin : g_len_check
		$error("LEN_W too small for the frame limits");
	end

	gfp_pkg::top_s s; // Registered state
	gfp_pkg::top_s next_s; // Next state

	logic accept; // Address phase taken this cycle
	logic [4:0] map; // Decoded {hit, index}

	// Decode a byte address into {hit, index}
	function automatic logic [4:0] map_addr(input logic [31:0] a);
		logic hit;
		hit = (a[31:6] == 26'h0) && (a[1:0] == 2'h0) &&
			((a[5:2] == `GFP_IDX_GC1) || (a[5:2] == `GFP_IDX_GC2));
		map_addr = {hit, a[5:2]};
	endfunction : map_addr

	// Read view of a register; unmapped and absent bits give zero
	function automatic logic [31:0] read_word(input gfp_pkg::top_s st,
			input logic [3:0] idx);
		read_word = 32'h0000_0000;
		if (idx == `GFP_IDX_GC1) begin
			read_word[`GFP_GC1_BACKOFF] = st.gc1_backoff;
		end else if (idx == `GFP_IDX_GC2) begin
			read_word[7:0] = st.gc2;
		end
	endfunction : read_word

	// Address phase is taken only once straps have landed
	assign map = map_addr(haddr);
	assign accept = hsel && hready && htrans[TRANS_ACTIVE] &&
		(s.phase == gfp_pkg::ST_RUN);

	// Next state: strap loading, register writes, read capture
	always_comb begin
		next_s = s;
		// Two-stage strap synchroniser; first stage feeds only the second
		next_s.strap_meta = {frame_size_strap_pin, collision_drop_strap_pin,
			backoff_strap_pin};
		next_s.strap_sync = s.strap_meta;
		// Strap sequence
		case (s.phase)
			gfp_pkg::ST_HOLD: begin
				// First edge after reset starts the settle count
				next_s.phase = gfp_pkg::ST_SETTLE;
				next_s.settle = 2'h0;
			end
			gfp_pkg::ST_SETTLE: begin
				if (s.settle == `GFP_STRAP_SETTLE) begin
					// Pins sampled once here; never looked at again
					next_s.gc1_backoff = s.strap_sync[`GFP_STRAP_BACKOFF];
					next_s.gc2[`GFP_GC2_KEEP_COLL] = s.strap_sync[`GFP_STRAP_COLL];
					next_s.gc2[`GFP_GC2_LEGAL_OFF] = s.strap_sync[`GFP_STRAP_SIZE];
					next_s.phase = gfp_pkg::ST_RUN;
				end else begin
					next_s.settle = s.settle + 2'h1;
				end
			end
			gfp_pkg::ST_RUN: begin
				// Software owns the bits from here on
				next_s.phase = gfp_pkg::ST_RUN;
			end
			default: begin
				next_s.phase = gfp_pkg::ST_HOLD;
			end
		endcase
		// Data phase of a write completes on hready
		if (s.dp_write && hready) begin
			next_s.dp_write = 1'b0;
			// Index was already checked against the map at the address phase
			if (s.dp_index == `GFP_IDX_GC1) begin
				next_s.gc1_backoff = hwdata[`GFP_GC1_BACKOFF];
			end else begin
				// Reserved bits 7 and 5 store what software writes
				next_s.gc2 = hwdata[7:0];
			end
		end
		// New address phase
		if (accept) begin
			// Non-word and unmapped writes are taken but dropped
			next_s.dp_write = hwrite && map[4] && (hsize == SIZE_WORD);
			next_s.dp_index = map[3:0];
			// Read sees a write finishing in the same cycle
			if (!hwrite) begin
				// Aliases above the map must read zero, not a register
				if (map[4]) begin
					next_s.rdata = read_word(next_s, map[3:0]);
				end else begin
					next_s.rdata = 32'h0000_0000;
				end
			end
		end
	end

	// State register; straps arrive later by the clocked sequence
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '{phase: gfp_pkg::ST_HOLD, settle: 2'h0, strap_meta: 3'h0,
				strap_sync: 3'h0, gc1_backoff: 1'b0, gc2: `GFP_GC2_RESET,
				dp_write: 1'b0, dp_index: 4'h0, rdata: 32'h0000_0000};
		end else begin
			s <= next_s;
		end
	end

	// Bus answers: zero wait once running, always OKAY
	assign hreadyout = (s.phase == gfp_pkg::ST_RUN);
	assign hresp = 1'b0;
	assign hrdata = s.rdata;

	// Backoff choice goes straight to the half-duplex MACs
	assign aggressive_backoff = s.gc1_backoff;

	// Per-frame decisions
	frame_policy_judge #(
		.LEN_W(LEN_W)
	) u_judge (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.bcast_only(s.gc2[`GFP_GC2_BCAST_ONLY]),
		.fair_mode(s.gc2[`GFP_GC2_FAIR]),
		.keep_coll(s.gc2[`GFP_GC2_KEEP_COLL]),
		.jumbo(s.gc2[`GFP_GC2_JUMBO]),
		.legal_off(s.gc2[`GFP_GC2_LEGAL_OFF]),
		.frame_valid(frame_valid),
		.frame_len(frame_len),
		.frame_tagged(frame_tagged),
		.frame_special_tag_id(frame_special_tag_id),
		.frame_drop(frame_drop),
		.frame_accept(frame_accept),
		.coll_event(coll_event),
		.coll_count(coll_count),
		.coll_discard(coll_discard),
		.dest_valid(dest_valid),
		.dest_bcast(dest_bcast),
		.dest_mcast(dest_mcast),
		.storm_hit(storm_hit),
		.fc_contend(fc_contend),
		.nonfc_drop_en(nonfc_drop_en),
		.fc_pause(fc_pause)
	);

	// All checks below run on sys_clk and rest while reset is low
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// Data phase of a write to each register
	sequence wr_gc1;
		s.dp_write && hready && (s.dp_index == `GFP_IDX_GC1);
	endsequence
	sequence wr_gc2;
		s.dp_write && hready && (s.dp_index == `GFP_IDX_GC2);
	endsequence
	// First cycle the bus is served
	sequence straps_landed;
		$rose(hreadyout);
	endsequence

	a_backoff_write: assert property (wr_gc1 |=>
		aggressive_backoff == $past(hwdata[`GFP_GC1_BACKOFF]))
		else $error("backoff write lost");
	a_backoff_strap: assert property (straps_landed |->
		aggressive_backoff == $past(s.strap_sync[`GFP_STRAP_BACKOFF]))
		else $error("backoff strap not loaded");
	a_fair_reset: assert property (straps_landed |->
		s.gc2[`GFP_GC2_FAIR] && s.gc2[7] && s.gc2[6] && s.gc2[5] && !s.gc2[2])
		else $error("reset value wrong");
	a_coll_strap: assert property (straps_landed |->
		s.gc2[`GFP_GC2_KEEP_COLL] == $past(s.strap_sync[`GFP_STRAP_COLL]))
		else $error("collision strap not loaded");
	a_size_strap: assert property (straps_landed |->
		s.gc2[`GFP_GC2_LEGAL_OFF] == $past(s.strap_sync[`GFP_STRAP_SIZE]))
		else $error("size strap not loaded");
	a_gc2_write: assert property (wr_gc2 |=> s.gc2 == $past(hwdata[7:0]))
		else $error("policy write lost");
	a_strap_settle: assert property ($fell(hreadyout) |-> 1'b0)
		else $error("bus blocked after straps landed");
	a_read_back: assert property (accept && !hwrite && map[4]
		&& map[3:0] == `GFP_IDX_GC2 && !s.dp_write |=> hrdata[7:0] == s.gc2)
		else $error("read data wrong");
	a_fair_route: assert property (fc_contend && s.gc2[`GFP_GC2_FAIR] |=>
		nonfc_drop_en && !fc_pause) else $error("fair mode not applied");
	a_unfair_route: assert property (fc_contend && !s.gc2[`GFP_GC2_FAIR] |=>
		fc_pause && !nonfc_drop_en) else $error("flow control not applied");
	a_jumbo_wins: assert property (frame_valid && s.gc2[`GFP_GC2_JUMBO]
		&& frame_len == LEN_W'(`GFP_LEN_JUMBO) |=> frame_accept)
		else $error("jumbo did not override");

	// Frame offered under each size policy
	sequence jumbo_frame;
		frame_valid && s.gc2[`GFP_GC2_JUMBO];
	endsequence
	sequence legal_frame;
		frame_valid && !s.gc2[`GFP_GC2_JUMBO] && s.gc2[`GFP_GC2_LEGAL_OFF];
	endsequence
	sequence std_frame;
		frame_valid && !s.gc2[`GFP_GC2_JUMBO] && !s.gc2[`GFP_GC2_LEGAL_OFF];
	endsequence

	// Size limits, checked at the top against the stored policy bits
	a_jumbo_drop: assert property (jumbo_frame ##0
		(frame_len > LEN_W'(`GFP_LEN_JUMBO)) |=> frame_drop)
		else $error("oversized jumbo frame kept");
	a_legal_edge: assert property (legal_frame ##0
		(frame_len == LEN_W'(`GFP_LEN_LEGAL)) |=> frame_accept)
		else $error("legal-size limit not inclusive");
	a_legal_over: assert property (legal_frame ##0
		(frame_len > LEN_W'(`GFP_LEN_LEGAL)) |=> frame_drop)
		else $error("frame over legal size kept");
	a_tag_edge: assert property (std_frame ##0 (frame_tagged && !frame_special_tag_id
		&& frame_len == LEN_W'(`GFP_LEN_TAGGED)) |=> frame_accept)
		else $error("tagged limit not inclusive");
	a_tag_over: assert property (std_frame ##0 (frame_tagged && !frame_special_tag_id
		&& frame_len > LEN_W'(`GFP_LEN_TAGGED)) |=> frame_drop)
		else $error("tagged frame over limit kept");
	a_untag_edge: assert property (std_frame ##0 (!frame_tagged
		&& frame_len == LEN_W'(`GFP_LEN_UNTAGGED)) |=> frame_accept)
		else $error("untagged limit not inclusive");
	a_untag_over: assert property (std_frame ##0 (!frame_tagged
		&& frame_len > LEN_W'(`GFP_LEN_UNTAGGED)) |=> frame_drop)
		else $error("untagged frame over limit kept");
	a_special_tag: assert property (std_frame ##0 (frame_special_tag_id
		&& frame_len > LEN_W'(`GFP_LEN_UNTAGGED)) |=> frame_drop)
		else $error("special tag got tagged limit");

	// Collision and storm decisions follow the stored bits
	a_keep_coll: assert property (coll_event && s.gc2[`GFP_GC2_KEEP_COLL]
		|=> !coll_discard) else $error("kept collision frame discarded");
	a_coll_discard: assert property (coll_event && !s.gc2[`GFP_GC2_KEEP_COLL]
		&& coll_count >= `GFP_COLL_LIMIT |=> coll_discard)
		else $error("excessive collision frame kept");
	a_bcast_storm: assert property (dest_valid && dest_bcast |=> storm_hit)
		else $error("broadcast not regulated");
	a_mcast_storm: assert property (dest_valid && dest_mcast
		&& !s.gc2[`GFP_GC2_BCAST_ONLY] |=> storm_hit)
		else $error("multicast not regulated");

	// Once running, only a bus write moves a policy bit; the pins no longer count
	a_backoff_hold: assert property (hreadyout
		&& !(s.dp_write && s.dp_index == `GFP_IDX_GC1) |=> $stable(aggressive_backoff))
		else $error("backoff changed without a write");
	a_policy_hold: assert property (hreadyout && !s.dp_write |=> $stable(s.gc2))
		else $error("policy changed without a write");

endmodule : switch_global_frame_policy
`default_nettype wire

// ==== logic/gfp_defines.svh ====
// Offsets, field positions, reset values and limits of the frame policy slice.
// Included by the register slice and the frame judge; no code lives here.
// What this block does
// - Backoff bit selects aggressive half-duplex backoff
// - Fair mode may drop non-flow-controlled frames
// - Fair mode off flow-controls the flow-controlled port
// - Fair mode bit resets to one, read-write
// - Keep bit stops discard after sixteen collisions
// - Jumbo bit accepts frames up to 1916
// - Jumbo clear leaves limit to legal-size bit
// - Legal-size bit alone accepts up to 1536
// - Both clear: 1522 tagged, 1518 untagged or with the special tag id
`ifndef GFP_DEFINES_SVH
`define GFP_DEFINES_SVH

// Register indices; byte address is four times the index
`define GFP_IDX_GC1 4'h3
`define GFP_IDX_GC2 4'h4

// Field positions
`define GFP_GC1_BACKOFF 0
`define GFP_GC2_BCAST_ONLY 6
`define GFP_GC2_FAIR 4
`define GFP_GC2_KEEP_COLL 3
`define GFP_GC2_JUMBO 2
`define GFP_GC2_LEGAL_OFF 1

// Reset value before straps land (bits 7,6,5,4 set)
`define GFP_GC2_RESET 8'hF0

// Strap positions in the synchroniser
`define GFP_STRAP_BACKOFF 0
`define GFP_STRAP_COLL 1
`define GFP_STRAP_SIZE 2

// Cycles the synchronised straps settle before loading
`define GFP_STRAP_SETTLE 2'h2

// Frame limits in bytes and the collision count
`define GFP_LEN_JUMBO 11'h77C
`define GFP_LEN_LEGAL 11'h600
`define GFP_LEN_TAGGED 11'h5F2
`define GFP_LEN_UNTAGGED 11'h5EE
`define GFP_COLL_LIMIT 5'h10

`endif

// ==== logic/gfp_pkg.sv ====
// Types shared by the frame policy register slice and its judge.
// Assumes the constants header is included by each user.
`default_nettype none
package gfp_pkg;

	// Strap loading sequence after reset
	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_SETTLE = 2'b01,
		ST_RUN = 2'b10
	} strap_state_e;

	// Register slice state
	typedef struct packed {
		strap_state_e phase;
		logic [1:0] settle;
		logic [2:0] strap_meta;
		logic [2:0] strap_sync;
		logic gc1_backoff;
		logic [7:0] gc2;
		logic dp_write;
		logic [3:0] dp_index;
		logic [31:0] rdata;
	} top_s;

	// Frame judge state
	typedef struct packed {
		logic frame_drop;
		logic frame_accept;
		logic coll_discard;
		logic storm_hit;
		logic nonfc_drop_en;
		logic fc_pause;
	} judge_s;

endpackage : gfp_pkg
`default_nettype wire

// ==== logic/frame_policy_judge.sv ====
// Per-frame decisions taken from the policy bits.
// Assumes all request inputs come from logic on sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "gfp_defines.svh"
module frame_policy_judge #(
	parameter int LEN_W = 11 // Frame length width
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Policy bits
	input wire logic bcast_only,
	input wire logic fair_mode,
	input wire logic keep_coll,
	input wire logic jumbo,
	input wire logic legal_off,
	// Frame length check
	input wire logic frame_valid,
	input wire logic [LEN_W-1:0] frame_len,
	input wire logic frame_tagged,
	input wire logic frame_special_tag_id,
	output logic frame_drop,
	output logic frame_accept,
	// Collisions
	input wire logic coll_event,
	input wire logic [4:0] coll_count,
	output logic coll_discard,
	// Storm classification
	input wire logic dest_valid,
	input wire logic dest_bcast,
	input wire logic dest_mcast,
	output logic storm_hit,
	// Egress contention
	input wire logic fc_contend,
	output logic nonfc_drop_en,
	output logic fc_pause
);

	// Limits are 11 bits wide
	if (LEN_W < 11) begin : g_len_check
		$error("LEN_W too small for 1916");
	end

	gfp_pkg::judge_s s; // Registered state
	gfp_pkg::judge_s next_s; // Next state

	// Longest frame accepted under the current policy
	function automatic logic [LEN_W-1:0] max_len(input logic jb, input logic lo,
			input logic tg, input logic sp);
		if (jb) begin
			max_len = LEN_W'(`GFP_LEN_JUMBO);
		end else if (lo) begin
			max_len = LEN_W'(`GFP_LEN_LEGAL);
		end else if (tg && !sp) begin
			max_len = LEN_W'(`GFP_LEN_TAGGED);
		end else begin
			max_len = LEN_W'(`GFP_LEN_UNTAGGED);
		end
	endfunction : max_len

	// Decisions; pulses last one cycle, contention is a level
	always_comb begin
		next_s = '0;
		// Length verdict
		if (frame_valid) begin
			next_s.frame_drop = frame_len > max_len(jumbo, legal_off, frame_tagged,
				frame_special_tag_id);
			next_s.frame_accept = !next_s.frame_drop;
		end
		// Excessive collisions discard only when not kept
		next_s.coll_discard = coll_event && (coll_count >= `GFP_COLL_LIMIT) && !keep_coll;
		// Broadcast always counts; multicast only when included
		next_s.storm_hit = dest_valid && (dest_bcast || (dest_mcast && !bcast_only));
		// Fair mode sacrifices the port without flow control
		next_s.nonfc_drop_en = fc_contend && fair_mode;
		next_s.fc_pause = fc_contend && !fair_mode;
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign frame_drop = s.frame_drop;
	assign frame_accept = s.frame_accept;
	assign coll_discard = s.coll_discard;
	assign storm_hit = s.storm_hit;
	assign nonfc_drop_en = s.nonfc_drop_en;
	assign fc_pause = s.fc_pause;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	a_jumbo_limit: assert property (frame_valid && jumbo |=>
		frame_drop == ($past(frame_len) > LEN_W'(`GFP_LEN_JUMBO)))
		else $error("jumbo limit wrong");
	a_legal_limit: assert property (frame_valid && !jumbo && legal_off |=>
		frame_drop == ($past(frame_len) > LEN_W'(`GFP_LEN_LEGAL)))
		else $error("legal-size limit wrong");
	a_std_tagged: assert property (frame_valid && !jumbo && !legal_off && frame_tagged
		&& !frame_special_tag_id |=> frame_drop == ($past(frame_len) > LEN_W'(`GFP_LEN_TAGGED)))
		else $error("tagged limit wrong");
	a_storm_bcast: assert property (dest_valid && bcast_only && !dest_bcast
		|=> !storm_hit) else $error("multicast regulated");
	a_coll_drop: assert property (coll_event && coll_count >= `GFP_COLL_LIMIT
		|=> coll_discard != $past(keep_coll)) else $error("collision drop wrong");
	a_fair_split: assert property (fc_contend |=>
		(nonfc_drop_en ^ fc_pause) && (fc_pause == !$past(fair_mode)))
		else $error("fair mode split wrong");

endmodule : frame_policy_judge
`default_nettype wire

// ==== bench/host_ahb_master.sv ====
// Host model: one single word AHB-Lite transfer per request.
// Assumes one slave whose hreadyout is wired back as hready.
`timescale 1ns/10ps
`default_nettype none
module host_ahb_master (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Request side
	input wire logic req,
	input wire logic [31:0] req_addr,
	input wire logic req_write,
	input wire logic [31:0] req_wdata,
	output logic done,
	output logic [31:0] rdata,
	// AHB-Lite master
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	logic [1:0] phase; // Idle, address phase, data phase
	logic [31:0] wd; // Write data kept for the data phase
	assign hsel = 1'b1; // Single slave, htrans qualifies
	assign hsize = 3'h2; // Whole words only
	// Address and data phases are held until hready is sampled high
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= 2'h0;
			htrans <= 2'h0;
			haddr <= 32'h0;
			hwrite <= 1'b0;
			hwdata <= 32'h0;
			wd <= 32'h0;
			done <= 1'b0;
			rdata <= 32'h0;
		end else begin
			done <= 1'b0;
			case (phase)
				2'h0: if (req) begin
					phase <= 2'h1;
					htrans <= 2'h2;
					haddr <= req_addr;
					hwrite <= req_write;
					wd <= req_wdata;
				end
				2'h1: if (hready) begin
					phase <= 2'h2;
					htrans <= 2'h0;
					hwdata <= wd;
				end
				default: if (hready) begin
					phase <= 2'h0;
					done <= 1'b1;
					rdata <= hrdata;
					// Released data lines must not look valid
					hwdata <= ~hwdata;
				end
			endcase
		end
	end
endmodule : host_ahb_master
`default_nettype wire

// ==== bench/tb_top.sv ====
// Bench for the frame policy register slice and its frame judge.
// Assumes the host model in host_ahb_master and straps held around reset.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic sys_clk, rst_b, req, req_write, done, hsel, hwrite, hreadyout, hresp;
	logic [31:0] req_addr, req_wdata, rdata, haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, straps; // Straps: size, collision, backoff
	logic aggressive_backoff, frame_valid, frame_tagged, frame_special_tag_id;
	logic frame_drop, frame_accept, coll_event, coll_discard, dest_valid;
	logic dest_bcast, dest_mcast, storm_hit, fc_contend, nonfc_drop_en, fc_pause;
	logic [10:0] frame_len;
	logic [4:0] coll_count;
	int fails = 0;
	int total_checks = 0;
	// Bus master model drives the register bus
	host_ahb_master host (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .req_addr(req_addr),
		.req_write(req_write), .req_wdata(req_wdata), .done(done), .rdata(rdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
	switch_global_frame_policy dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.backoff_strap_pin(straps[0]), .collision_drop_strap_pin(straps[1]),
		.frame_size_strap_pin(straps[2]), .aggressive_backoff(aggressive_backoff),
		.frame_valid(frame_valid), .frame_len(frame_len), .frame_tagged(frame_tagged),
		.frame_special_tag_id(frame_special_tag_id), .frame_drop(frame_drop),
		.frame_accept(frame_accept), .coll_event(coll_event), .coll_count(coll_count),
		.coll_discard(coll_discard), .dest_valid(dest_valid), .dest_bcast(dest_bcast),
		.dest_mcast(dest_mcast), .storm_hit(storm_hit), .fc_contend(fc_contend),
		.nonfc_drop_en(nonfc_drop_en), .fc_pause(fc_pause));
	// 100 MHz clock
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;
	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Verdict and end of run
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	// One bus transfer; waits for the host, bounded so a stall cannot hang
	task xfer(input logic [31:0] a, input logic w, input logic [31:0] wv);
		int n;
		n = 0;
		@(posedge sys_clk);
		req <= 1'b1;
		req_addr <= a;
		req_write <= w;
		req_wdata <= wv;
		@(posedge sys_clk);
		req <= 1'b0;
		while (done !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		check(done, 1'b1);
	endtask : xfer
	task rd(input logic [31:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		check(rdata, exp);
	endtask : rd
	// Reset with the given strap levels, held past the load
	task do_reset(input logic [2:0] s);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		straps <= s;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
	endtask : do_reset
	// Drop strobes at the edge that takes them; outputs are read one edge later
	task settle;
		@(posedge sys_clk);
		frame_valid <= 1'b0;
		coll_event <= 1'b0;
		dest_valid <= 1'b0;
		fc_contend <= 1'b0;
		@(posedge sys_clk);
	endtask : settle
	// Policy write, then one event of the task's own kind
	task frame(input logic [7:0] r, input logic [10:0] len, input logic tg, sp, d);
		xfer(32'h10, 1'b1, {24'h0, r});
		frame_valid <= 1'b1;
		frame_len <= len;
		frame_tagged <= tg;
		frame_special_tag_id <= sp;
		settle;
		check(frame_drop, d);
		check(frame_accept, !d);
	endtask : frame
	task coll(input logic [7:0] r, input logic [4:0] c, input logic d);
		xfer(32'h10, 1'b1, {24'h0, r});
		coll_event <= 1'b1;
		coll_count <= c;
		settle;
		check(coll_discard, d);
	endtask : coll
	task storm(input logic [7:0] r, input logic b, m, h);
		xfer(32'h10, 1'b1, {24'h0, r});
		dest_valid <= 1'b1;
		dest_bcast <= b;
		dest_mcast <= m;
		settle;
		check(storm_hit, h);
	endtask : storm
	task cont(input logic [7:0] r, input logic d, p);
		xfer(32'h10, 1'b1, {24'h0, r});
		fc_contend <= 1'b1;
		settle;
		check(nonfc_drop_en, d);
		check(fc_pause, p);
	endtask : cont
	// Main sequence; policy values always keep bits 7 and 5 at one
	initial begin
		{rst_b, req, req_write, frame_valid, frame_tagged} = 5'h0;
		{frame_special_tag_id, coll_event, dest_valid, dest_bcast} = 4'h0;
		{dest_mcast, fc_contend} = 2'h0;
		{req_addr, req_wdata} = 64'h0;
		{straps, frame_len, coll_count} = 19'h0;
		do_reset(3'h3);
		rd(32'h10, 32'hF8);
		rd(32'h0C, 32'h1);
		check(aggressive_backoff, 1'b1);
		check(hresp, 1'b0);
		straps <= 3'h4;
		rd(32'h10, 32'hF8);
		do_reset(3'h4);
		rd(32'h10, 32'hF2);
		rd(32'h0C, 32'h0);
		check(aggressive_backoff, 1'b0);
		xfer(32'h0C, 1'b1, 32'h1);
		check(aggressive_backoff, 1'b1);
		xfer(32'h10, 1'b1, 32'hA0);
		rd(32'h10, 32'hA0);
		xfer(32'h20, 1'b1, 32'hFF);
		rd(32'h20, 32'h0);
		xfer(32'h50, 1'b1, 32'hFF);
		rd(32'h50, 32'h0);
		rd(32'h10, 32'hA0);
		frame(8'hA0, 11'h5EE, 1'b0, 1'b0, 1'b0);
		frame(8'hA0, 11'h5EF, 1'b0, 1'b0, 1'b1);
		frame(8'hA0, 11'h5F2, 1'b1, 1'b0, 1'b0);
		frame(8'hA0, 11'h5F3, 1'b1, 1'b0, 1'b1);
		frame(8'hA0, 11'h5EF, 1'b1, 1'b1, 1'b1);
		frame(8'hA2, 11'h600, 1'b1, 1'b0, 1'b0);
		frame(8'hA2, 11'h601, 1'b0, 1'b0, 1'b1);
		frame(8'hA4, 11'h77C, 1'b0, 1'b0, 1'b0);
		frame(8'hA6, 11'h77D, 1'b1, 1'b0, 1'b1);
		frame(8'hA6, 11'h77C, 1'b0, 1'b0, 1'b0);
		coll(8'hA0, 5'h10, 1'b1);
		coll(8'hA0, 5'h0F, 1'b0);
		coll(8'hA8, 5'h10, 1'b0);
		coll(8'hA8, 5'h1F, 1'b0);
		storm(8'hE0, 1'b1, 1'b0, 1'b1);
		storm(8'hE0, 1'b0, 1'b1, 1'b0);
		storm(8'hA0, 1'b0, 1'b1, 1'b1);
		storm(8'hA0, 1'b0, 1'b0, 1'b0);
		cont(8'hB0, 1'b1, 1'b0);
		cont(8'hA0, 1'b0, 1'b1);
		print_verdict;
	end
	// Watchdog; the whole sequence needs a few hundred cycles
	initial begin
		#100000;
		fails++;
		print_verdict;
	end
endmodule : tb_top
`default_nettype wire
